//--- s8t_map.svh
`ifndef S8T_MAP_SVH
`define S8T_MAP_SVH

// ----------------------------------------------------------------------
// Byte timing
// ----------------------------------------------------------------------
// Bit cycles per byte time, and the last count of the byte counter
`define S8T_BYTE_BITS 10
`define S8T_CNT_LAST 4'h9
// Read pulse is low from this count through the last one
`define S8T_RP_LOW_FIRST 4'h5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define S8T_LFSR_SEED 9'h1FF
`define S8T_CNT_RST 4'h0
`define S8T_SYM_RST 10'h000

// ----------------------------------------------------------------------
// Code points
// ----------------------------------------------------------------------
`define S8T_K28 5'h1C
`define S8T_COMMA_BYTE 8'hBC
`define S8T_K28_6B 6'h0F
`define S8T_VIOL_NEG 10'h278
`define S8T_VIOL_POS 10'h187

`endif

//--- s8t_pkg.sv
package s8t_pkg;

  // Ten-bit line symbol, bit 9 is bit a and leaves first
  typedef logic [9:0] s8t_sym_t;

  // Position inside a byte time
  typedef logic [3:0] s8t_cnt_t;

  // Source of the symbol handed to the shifter
  typedef enum logic [2:0] {
    S8T_SRC_DATA = 3'h1,
    S8T_SRC_COMMA = 3'h2,
    S8T_SRC_VIOL = 3'h4
  } s8t_src_t;

endpackage

//--- s8t_ser_if.sv
`timescale 1ns/1ps

// Symbol hand-off from the encoder to the shifter
interface s8t_ser_if;
  s8t_pkg::s8t_sym_t sym;
  logic load;
  modport ctl (output sym, output load);
  modport ser (input sym, input load);
endinterface

//--- s8t_clkgen.sv
`timescale 1ns/1ps
`include "s8t_map.svh"

module s8t_clkgen (
  // Clock and reset
  input logic sys_clk,
  input logic reset,
  input logic clk_en,
  // Byte timing
  output s8t_pkg::s8t_cnt_t bit_count,
  output logic load_strobe,
  output logic fifo_read_pulse_n
);
  import s8t_pkg::*;

  s8t_cnt_t next_count;

  // Next value of the free-running byte counter
  always_comb begin
    if (bit_count == `S8T_CNT_LAST) begin
      next_count = `S8T_CNT_RST;
    end else begin
      next_count = bit_count + 4'h1;
    end
  end

  // Byte counter, the only source of load timing
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bit_count <= `S8T_CNT_RST;
    end else if (clk_en) begin
      bit_count <= next_count;
    end
  end

  // Shifter takes a new symbol on the last bit of each byte
  assign load_strobe = (bit_count == `S8T_CNT_LAST);

  // Read pulse from the counter, half a byte wide, no input clock duty
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fifo_read_pulse_n <= 1'b1;
    end else if (clk_en) begin
      fifo_read_pulse_n <= !(next_count >= `S8T_RP_LOW_FIRST);
    end
  end

endmodule

//--- s8t_serializer.sv
`timescale 1ns/1ps
`include "s8t_map.svh"

module s8t_serializer (
  // Clock and reset
  input logic sys_clk,
  input logic reset,
  input logic clk_en,
  // Symbol from the encoder
  s8t_ser_if.ser link,
  // Output control
  input logic optical_output_off,
  // Serial outputs
  output logic serial_out_primary,
  output logic serial_out_secondary,
  output logic serial_out_loopback
);
  import s8t_pkg::*;

  s8t_sym_t shreg;
  logic off_q;

  // Parallel load once per byte, then shift bit a first
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      shreg <= `S8T_SYM_RST;
    end else if (clk_en) begin
      if (link.load) begin
        shreg <= link.sym;
      end else begin
        shreg <= {shreg[8:0], 1'b0};
      end
    end
  end

  // Output off is taken as it comes, not aligned to bytes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      off_q <= 1'b0;
    end else if (clk_en) begin
      off_q <= optical_output_off;
    end
  end

  // Three identical streams, two of them gated to zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      serial_out_primary <= 1'b0;
      serial_out_secondary <= 1'b0;
      serial_out_loopback <= 1'b0;
    end else if (clk_en) begin
      serial_out_primary <= shreg[9] & ~off_q;
      serial_out_secondary <= shreg[9] & ~off_q;
      serial_out_loopback <= shreg[9];
    end
  end

endmodule

//--- s8t_tx.sv
// Function
// - Byte clock rising edge captures data, special select and violation request.
// - Load-now enable low at an edge loads the present inputs.
// - Load-next enable low at an edge loads the inputs at next edge.
// - No enable low at an edge, outside self-test and with no load-next pending, sends the comma for that byte.
// - Self-test turns the input register into a 511-byte LFSR pattern.
// - Special select high uses special table, low uses data table.
// - Violation request sends a code violation symbol instead, fixed for each running disparity; in bypass it passes as a raw bit.
// - Bypass mode passes ten raw input bits straight to the shifter.
// - In bypass, bit a leaves first, then on through bit j.
// - Shifter takes one ten-bit word per byte, shifts at tenfold rate.
// - Shifter load timing comes only from the internal byte counter.
// - All three outputs match; output off forces primary, secondary to zero.
// - Loopback output ignores output off and always carries the stream.
// - Output off is unsynchronised and acts within bits, even mid-byte.
// - Byte-rate read pulse from the counter, width independent of clock.
// - The comma symbol marks byte boundaries for the far receiver.
`timescale 1ns/1ps
`include "s8t_map.svh"

module s8t_tx (
  // Clock, reset and clock enable
  input logic sys_clk,
  input logic reset,
  input logic clk_en,
  // Byte input side
  input logic byte_write_clock,
  input logic load_now_enable_n,
  input logic load_next_enable_n,
  input logic [7:0] tx_data,
  input logic special_char_select,
  input logic send_violation_symbol,
  // Mode control
  input logic bypass_mode,
  input logic self_test_enable,
  // Serial side
  input logic optical_output_off,
  output logic serial_out_primary,
  output logic serial_out_secondary,
  output logic serial_out_loopback,
  output logic fifo_read_pulse_n,
  // Status
  output logic running_disparity,
  output logic comma_sent
);
  import s8t_pkg::*;

  // ----------------------------------------------------------------------
  // Code tables
  // ----------------------------------------------------------------------

  // Six-bit sub-block abcdei for a data value, negative-disparity form
  function automatic logic [5:0] six_neg(input logic [4:0] x);
    logic [5:0] v;
    v = 6'h00;
    case (x)
      5'h00: v = 6'h27;
      5'h01: v = 6'h1D;
      5'h02: v = 6'h2D;
      5'h03: v = 6'h31;
      5'h04: v = 6'h35;
      5'h05: v = 6'h29;
      5'h06: v = 6'h19;
      5'h07: v = 6'h38;
      5'h08: v = 6'h39;
      5'h09: v = 6'h25;
      5'h0A: v = 6'h15;
      5'h0B: v = 6'h34;
      5'h0C: v = 6'h0D;
      5'h0D: v = 6'h2C;
      5'h0E: v = 6'h1C;
      5'h0F: v = 6'h17;
      5'h10: v = 6'h1B;
      5'h11: v = 6'h23;
      5'h12: v = 6'h13;
      5'h13: v = 6'h32;
      5'h14: v = 6'h0B;
      5'h15: v = 6'h2A;
      5'h16: v = 6'h1A;
      5'h17: v = 6'h3A;
      5'h18: v = 6'h33;
      5'h19: v = 6'h26;
      5'h1A: v = 6'h16;
      5'h1B: v = 6'h36;
      5'h1C: v = 6'h0E;
      5'h1D: v = 6'h2E;
      5'h1E: v = 6'h1E;
      default: v = 6'h2B;
    endcase
    return v;
  endfunction

  // Four-bit sub-block fghj, form used when entering with negative disparity
  function automatic logic [3:0] four_neg(input logic [2:0] y, input logic k,
                                          input logic alt);
    logic [3:0] v;
    v = 4'h0;
    case (y)
      3'h0: v = 4'hB;
      3'h1: v = k ? 4'h6 : 4'h9;
      3'h2: v = k ? 4'hA : 4'h5;
      3'h3: v = 4'hC;
      3'h4: v = 4'hD;
      3'h5: v = k ? 4'h5 : 4'hA;
      3'h6: v = k ? 4'h9 : 4'h6;
      default: v = alt ? 4'h7 : 4'hE;
    endcase
    return v;
  endfunction

  // Full encode: {symbol, disparity after, code valid}
  function automatic logic [11:0] encode(input logic [7:0] d, input logic k,
                                         input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] six;
    logic [3:0] four;
    logic rd_mid;
    logic rd_out;
    logic alt;
    logic ok;
    x = d[4:0];
    y = d[7:5];
    ok = !k || (x == `S8T_K28) ||
         ((y == 3'h7) && ((x == 5'h17) || (x == 5'h1B) || (x == 5'h1D) || (x == 5'h1E)));
    six = (k && (x == `S8T_K28)) ? `S8T_K28_6B : six_neg(x);
    if (rd && (($countones(six) != 3) || (!k && (x == 5'h07)))) begin
      six = ~six;
    end
    rd_mid = rd ^ ($countones(six) != 3);
    alt = (y == 3'h7) && (k || (!rd_mid && ((x == 5'h11) || (x == 5'h12) || (x == 5'h14)))
          || (rd_mid && ((x == 5'h0B) || (x == 5'h0D) || (x == 5'h0E))));
    four = four_neg(y, k, alt);
    if (rd_mid && (($countones(four) != 2) || k || (y == 3'h3))) begin
      four = ~four;
    end
    rd_out = rd_mid ^ ($countones(four) != 2);
    return {six, four, rd_out, ok};
  endfunction

  // ----------------------------------------------------------------------
  // Byte clock edge and self-test pattern
  // ----------------------------------------------------------------------

  logic ckw_prev;
  logic ckw_rise;
  logic load_pending;
  logic [8:0] lfsr;

  // Edge detector on the byte clock, sampled as a synchronous input
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ckw_prev <= 1'b0;
    end else if (clk_en) begin
      ckw_prev <= byte_write_clock;
    end
  end

  assign ckw_rise = byte_write_clock & ~ckw_prev;

  // Nine-bit maximal LFSR, one step per byte, covers every special byte and every data byte except 00
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lfsr <= `S8T_LFSR_SEED;
    end else if (clk_en) begin
      if (!self_test_enable) begin
        lfsr <= `S8T_LFSR_SEED;
      end else if (ckw_rise) begin
        lfsr <= {lfsr[7:0], lfsr[8] ^ lfsr[4]};
      end
    end
  end

  // Deferred load request taken at one edge and honoured at the next
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      load_pending <= 1'b0;
    end else if (clk_en && ckw_rise) begin
      load_pending <= !load_next_enable_n && !self_test_enable;
    end
  end

  // ----------------------------------------------------------------------
  // Input register
  // ----------------------------------------------------------------------

  logic [7:0] in_data;
  logic in_sc;
  logic in_svs;
  logic in_loaded;

  // Capture on the byte clock edge, from pins or from the pattern generator
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      in_data <= 8'h00;
      in_sc <= 1'b0;
      in_svs <= 1'b0;
      in_loaded <= 1'b0;
    end else if (clk_en && ckw_rise) begin
      if (self_test_enable) begin
        in_data <= lfsr[7:0];
        in_sc <= lfsr[8];
        in_svs <= 1'b0;
        in_loaded <= 1'b1;
      end else if (load_pending || !load_now_enable_n) begin
        in_data <= tx_data;
        in_sc <= special_char_select;
        in_svs <= send_violation_symbol;
        in_loaded <= 1'b1;
      end else begin
        in_loaded <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Encoder
  // ----------------------------------------------------------------------

  logic [11:0] enc_data;
  logic [11:0] enc_comma;
  logic load_strobe;
  s8t_src_t src;
  s8t_sym_t next_sym;
  logic next_rd;
  s8t_cnt_t bit_count;
  s8t_ser_if ser_link ();

  assign enc_data = encode(in_data, in_sc, running_disparity);
  assign enc_comma = encode(`S8T_COMMA_BYTE, 1'b1, running_disparity);

  // Symbol source: comma when idle, violation on request or on a bad special
  always_comb begin
    if (!in_loaded) begin
      src = S8T_SRC_COMMA;
    end else if (bypass_mode) begin
      src = S8T_SRC_DATA;
    end else if (in_svs || !enc_data[0]) begin
      src = S8T_SRC_VIOL;
    end else begin
      src = S8T_SRC_DATA;
    end
  end

  // Symbol and disparity chosen for the next byte time
  always_comb begin
    next_sym = enc_comma[11:2];
    next_rd = enc_comma[1];
    case (src)
      S8T_SRC_COMMA: begin
        next_sym = enc_comma[11:2];
        next_rd = enc_comma[1];
      end
      S8T_SRC_VIOL: begin
        next_sym = running_disparity ? `S8T_VIOL_POS : `S8T_VIOL_NEG;
        next_rd = running_disparity;
      end
      default: begin
        if (bypass_mode) begin
          // Raw word: select bit first, data bits 0 to 7, violation bit last
          next_sym = {in_sc, in_data[0], in_data[1], in_data[2], in_data[3],
                      in_data[4], in_data[5], in_data[6], in_data[7], in_svs};
          next_rd = running_disparity;
        end else begin
          next_sym = enc_data[11:2];
          next_rd = enc_data[1];
        end
      end
    endcase
  end

  // Running disparity advances only when the shifter takes a symbol
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      running_disparity <= 1'b0;
    end else if (clk_en && load_strobe) begin
      running_disparity <= next_rd;
    end
  end

  // Marks a byte time that carries the idle comma
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      comma_sent <= 1'b0;
    end else if (clk_en && load_strobe) begin
      comma_sent <= (src == S8T_SRC_COMMA);
    end
  end

  assign ser_link.sym = next_sym;
  assign ser_link.load = load_strobe;

  // ----------------------------------------------------------------------
  // Clock generator and shifter
  // ----------------------------------------------------------------------

  // Byte counter, shifter load timing and the FIFO read pulse
  s8t_clkgen u_clkgen (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .bit_count(bit_count),
    .load_strobe(load_strobe),
    .fifo_read_pulse_n(fifo_read_pulse_n)
  );

  // Serial shifter and the three output streams
  s8t_serializer u_serializer (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .link(ser_link.ser),
    .optical_output_off(optical_output_off),
    .serial_out_primary(serial_out_primary),
    .serial_out_secondary(serial_out_secondary),
    .serial_out_loopback(serial_out_loopback)
  );

endmodule

//--- s8t_tx_assertions.sv
`timescale 1ns/1ps
// -------------------------------------------
// Serial output and read pulse checks
// -------------------------------------------
module s8t_tx_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Observed pins
  input wire logic optical_output_off,
  input wire logic serial_out_primary,
  input wire logic serial_out_secondary,
  input wire logic serial_out_loopback,
  input wire logic fifo_read_pulse_n,
  input wire logic running_disparity,
  input wire logic comma_sent
);
  default clocking cb @(posedge sys_clk);
  endclocking
  // Frozen cycles move nothing, so no attempt runs across them
  default disable iff (reset || !clk_en);

  // Output pairs and the off control
  property p_sec_eq;
    serial_out_secondary == serial_out_primary;
  endproperty
  a_sec_eq: assert property (p_sec_eq)
    else $error("secondary differs from primary");
  property p_off_zero;
    $past(optical_output_off) && $past(optical_output_off, 2) |-> !serial_out_primary;
  endproperty
  a_off_zero: assert property (p_off_zero)
    else $error("primary not forced low");
  property p_loop_eq;
    !$past(optical_output_off) && !$past(optical_output_off, 2)
      |-> serial_out_primary == serial_out_loopback;
  endproperty
  a_loop_eq: assert property (p_loop_eq)
    else $error("loopback differs from primary");
  property p_off_resume;
    $fell(optical_output_off) |-> ##2 (serial_out_primary == serial_out_loopback) [*3];
  endproperty
  a_off_resume: assert property (p_off_resume)
    else $error("primary late after output on");

  // Byte timing and status
  property p_rp_shape;
    $fell(fifo_read_pulse_n) |-> !fifo_read_pulse_n [*5] ##1 fifo_read_pulse_n [*5];
  endproperty
  a_rp_shape: assert property (p_rp_shape)
    else $error("read pulse width wrong");
  property p_rp_period;
    $rose(fifo_read_pulse_n) |=> !$rose(fifo_read_pulse_n) [*8] ##1 !$rose(fifo_read_pulse_n)
      ##1 $rose(fifo_read_pulse_n);
  endproperty
  a_rp_period: assert property (p_rp_period)
    else $error("read pulse period wrong");
  property p_rd_hold;
    $changed(running_disparity) |=> $stable(running_disparity) [*8];
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("disparity changed within a byte");
  property p_comma_hold;
    $rose(comma_sent) |-> comma_sent [*8];
  endproperty
  a_comma_hold: assert property (p_comma_hold)
    else $error("comma flag too short");
endmodule

bind s8t_tx s8t_tx_checker s8t_tx_checker_inst (.sys_clk, .reset, .clk_en, .optical_output_off,
  .serial_out_primary, .serial_out_secondary, .serial_out_loopback, .fifo_read_pulse_n,
  .running_disparity, .comma_sent);

//--- s8t_fifo_model.sv
`timescale 1ns/1ps
// -------------------------------------------
// Byte source on the parallel side
// -------------------------------------------
module s8t_fifo_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Parallel side
  output logic byte_write_clock,
  output logic load_now_enable_n,
  output logic load_next_enable_n,
  output logic [7:0] tx_data,
  output logic special_char_select,
  output logic send_violation_symbol
);
  logic [10:0] q[$];
  logic [10:0] held;
  logic [9:0] w = 10'h000;
  logic [1:0] en;
  logic pend;
  int cc;

  // Quiet levels before the first edge
  initial begin
    byte_write_clock = 1'b0;
    {load_now_enable_n, load_next_enable_n} = 2'h3;
    {special_char_select, send_violation_symbol, tx_data} = 10'h000;
  end

  // Byte clock of ten cycles; one word per rise, idle lines show inverted data
  always @(negedge sys_clk) begin
    if (reset) begin
      cc = 9;
      pend = 0;
      byte_write_clock <= 1'b0;
      {load_now_enable_n, load_next_enable_n} <= 2'h3;
    end else begin
      cc = (cc + 1) % 10;
      byte_write_clock <= cc < 5;
      if (cc == 0) begin
        en = 2'h3;
        if (pend) begin
          pend = 0;
          w = held[9:0];
        end else if (q.size() > 0) begin
          held = q.pop_front();
          pend = held[10];
          en = {held[10], !held[10]};
          w = pend ? ~held[9:0] : held[9:0];
        end else begin
          w = ~w;
        end
        {load_now_enable_n, load_next_enable_n} <= en;
        {special_char_select, send_violation_symbol, tx_data} <= w;
      end
    end
  end
endmodule

//--- s8t_tx_tb.sv
`timescale 1ns/1ps
`include "s8t_map.svh"
// -------------------------------------------
// Transmit path bench
// -------------------------------------------
module s8t_tx_tb;
  import s8t_pkg::*;
  logic sys_clk = 0, reset = 1, clk_en = 1, bypass_mode = 0;
  logic self_test_enable = 0, optical_output_off = 0;
  logic byte_write_clock, load_now_enable_n, load_next_enable_n;
  logic special_char_select, send_violation_symbol, serial_out_primary, serial_out_secondary;
  logic serial_out_loopback, fifo_read_pulse_n, running_disparity, comma_sent;
  logic [7:0] tx_data;
  int mismatches = 0, tests_run = 0, exp_q[$];
  s8t_sym_t rec[$];
  s8t_sym_t sh, s;
  logic rd = 0, pr = 1, on = 0, raw = 0, en_q = 1;
  logic [31:0] seed = 96491;

  // Bit clock
  always #2 sys_clk = ~sys_clk;

  s8t_fifo_model s8t_fifo_model_inst (.sys_clk, .reset, .byte_write_clock,
    .load_now_enable_n, .load_next_enable_n, .tx_data, .special_char_select,
    .send_violation_symbol);
  s8t_tx s8t_tx_inst (.sys_clk, .reset, .clk_en, .byte_write_clock, .load_now_enable_n,
    .load_next_enable_n, .tx_data, .special_char_select, .send_violation_symbol, .bypass_mode,
    .self_test_enable, .optical_output_off, .serial_out_primary, .serial_out_secondary,
    .serial_out_loopback, .fifo_read_pulse_n, .running_disparity, .comma_sent);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected symbol: -1 comma, -2 violation, else a literal
  function automatic s8t_sym_t sym_of(int e);
    if (e == -1) return rd ? 10'h305 : 10'h0FA;
    if (e == -2) return rd ? `S8T_VIOL_POS : `S8T_VIOL_NEG;
    return e[9:0];
  endfunction

  task automatic check(logic ok, string m);
    tests_run++;
    if (!ok) begin
      mismatches++;
      $display("Error %0t: %s", $time, m);
    end
  endtask

  task automatic wrap_up();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic push(logic [10:0] w, int e);
    s8t_fifo_model_inst.q.push_back(w);
    exp_q.push_back(e);
  endtask

  task automatic drain();
    for (int i = 0; i < 400 && exp_q.size() > 0; i++) cyc(1);
    check(exp_q.size() == 0, "symbols missing");
    if (exp_q.size() > 0) wrap_up();
    cyc(30);
  endtask

  // Enable as seen at the last rising edge; a frozen edge moves no output bit
  always @(posedge sys_clk) en_q <= clk_en;

  // Symbol collector: a symbol ends where the read pulse rises
  always @(negedge sys_clk) begin
    if (en_q) begin
      s = {sh[8:0], serial_out_loopback};
      sh = s;
      if (fifo_read_pulse_n && !pr && on) begin
        if (raw) begin
          rec.push_back(s);
        end else if (exp_q.size() > 0 && s === sym_of(exp_q[0])) begin
          if (exp_q[0] == -1) rd = !rd;
          void'(exp_q.pop_front());
          tests_run++;
        end else begin
          check(s === sym_of(-1), "unexpected symbol");
          rd = !rd;
        end
      end
      pr = fifo_read_pulse_n;
    end
  end

  // Main sequence
  initial begin
    logic [10:0] w;
    s8t_sym_t e;
    logic [2:0] vk[3];
    vk = '{3'h1, 3'h3, 3'h5};
    cyc(2);
    reset = 0;
    cyc(12);
    on = 1;
    for (int i = 0; i < 40 && comma_sent !== 1'b1; i++) cyc(1);
    check(comma_sent === 1'b1, "no comma flag");
    cyc(60);
    // Raw words back to back, some through the load-next path
    bypass_mode = 1;
    for (int i = 0; i < 14; i++) begin
      w = 11'(rnd());
      e = {w[9], w[0], w[1], w[2], w[3], w[4], w[5], w[6], w[7], w[8]};
      if (e == 10'h0FA || e == 10'h305) continue;
      push(w, e);
    end
    drain();
    bypass_mode = 0;
    // Special against data table, violations, repeated specials
    push(11'h2BC, -1);
    push(11'h0BC, 10'h0EA);
    foreach (vk[k]) begin
      w = 11'(rnd());
      w[10:8] = vk[k];
      push(w, -2);
    end
    push(11'h2BC, -1);
    push(11'h2BC, -1);
    drain();
    // Outputs off at an arbitrary bit; loopback stays checked by the collector
    cyc(rnd() % 7);
    optical_output_off = 1;
    cyc(3);
    for (int i = 0; i < 30; i++) begin
      check(!serial_out_primary && !serial_out_secondary, "output not off");
      cyc(1);
    end
    optical_output_off = 0;
    cyc(40);
    // Freeze for a few cycles while idle commas flow; the stream must resume intact
    clk_en = 0;
    cyc(3 + rnd() % 5);
    clk_en = 1;
    cyc(40);
    // Self-test pattern repeats every 511 bytes
    raw = 1;
    self_test_enable = 1;
    for (int i = 0; i < 12000 && rec.size() < 1070; i++) cyc(1);
    check(rec.size() >= 1070, "pattern too short");
    if (rec.size() < 1070) wrap_up();
    // Disparity may differ after one loop of bytes, so two loops bring the symbols back
    for (int i = 20; i < 40; i++) check(rec[i] === rec[i + 1022], "pattern period");
    check(rec[20] !== rec[21] || rec[21] !== rec[22], "pattern static");
    // Second reset mid-run, idle commas start again from negative form
    self_test_enable = 0;
    on = 0;
    raw = 0;
    reset = 1;
    cyc(2);
    reset = 0;
    rd = 0;
    cyc(12);
    on = 1;
    cyc(50);
    wrap_up();
  end
endmodule
